// ---- sim/sbfs_master.sv ----
// Bus master model that drives the burst port's synchronous pins.
// Assumes the port samples on the rising edge of clk.
`timescale 1ns/1ps
module sbfs_master (
  // Clock
  input wire logic clk,
  // Address, selects and burst control
  output logic [18:0] addr,
  output logic pipelined_select_n,
  output logic depth_select_hi,
  output logic depth_select_lo_n,
  output logic processor_addr_strobe_n,
  output logic controller_addr_strobe_n,
  output logic burst_advance_n,
  output logic burst_order_interleave,
  // Write enables and data
  output logic [3:0] byte_write_lane_n,
  output logic byte_write_qualifier_n,
  output logic all_bytes_write_n,
  output logic [35:0] dq_w,
  // Resolved buses of the x36 and x18 ports
  input wire logic [35:0] dq_r,
  input wire logic [35:0] dq_r2,
  input wire logic dq_oe
);
  // Every change lands 1 ns after the rising edge
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic idle();
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
    {byte_write_lane_n, byte_write_qualifier_n, all_bytes_write_n} = 6'h3F;
  endtask
  initial begin
    {pipelined_select_n, depth_select_hi, depth_select_lo_n} = 3'h2;
    addr = 19'h00000;
    burst_order_interleave = 1'b0;
    dq_w = 36'h000000000;
    idle();
  end
  // Controller strobe opens a write burst
  task automatic wr(input logic [18:0] a, input logic [3:0][35:0] d, input logic [5:0] en_n);
    addr = a;
    controller_addr_strobe_n = 1'b0;
    for (int k = 0; k < 4; k++) begin
      {byte_write_lane_n, byte_write_qualifier_n, all_bytes_write_n} = en_n;
      dq_w = d[k];
      step();
      if (k < 3) begin
        controller_addr_strobe_n = 1'b1;
        burst_advance_n = 1'b0;
      end
    end
    idle();
    // Released data lines must not keep the last value
    dq_w = ~dq_w;
    // One idle edge so the next request never reassigns a pin in this time step
    step();
  endtask
  // Processor strobe opens a read burst
  task automatic rd(input logic [18:0] a, input logic il, output logic [3:0][35:0] d,
                    output logic [3:0] oe, output logic [3:0][35:0] d2);
    addr = a;
    burst_order_interleave = il;
    processor_addr_strobe_n = 1'b0;
    step();
    processor_addr_strobe_n = 1'b1;
    burst_advance_n = 1'b0;
    for (int k = 0; k < 4; k++) begin
      d[k] = dq_r;
      d2[k] = dq_r2;
      oe[k] = dq_oe;
      if (k < 3) step();
    end
    idle();
    step();
  endtask
endmodule // sbfs_master

// ---- sim/tb_top.sv ----
// Self-checking bench for the burst SRAM port in x36 and x18 form.
// Assumes the master model owns all synchronous pins.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic out_enable_n = 1'b0;
  logic sleep_request = 1'b0;
  logic [18:0] addr;
  logic pipelined_select_n, depth_select_hi, depth_select_lo_n;
  logic processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
  logic burst_order_interleave, byte_write_qualifier_n, all_bytes_write_n, dq_oe;
  logic [3:0] byte_write_lane_n;
  logic [35:0] dq_w, dq_out, dq_bus;
  logic [35:0] dq_out18, dq_bus18;
  logic dq_oe18;
  logic [3:0][35:0] d, d2;
  logic [3:0] oe;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  assign dq_bus = dq_oe ? dq_out : dq_w;
  assign dq_bus18 = dq_oe18 ? dq_out18 : dq_w;
  always #2 clk = ~clk;
  sbfs_port #(.ORG_X18(1'b0)) DUT (.clk, .rst_n, .addr, .pipelined_select_n,
    .depth_select_hi, .depth_select_lo_n, .processor_addr_strobe_n,
    .controller_addr_strobe_n, .burst_advance_n, .burst_order_interleave,
    .byte_write_lane_n, .byte_write_qualifier_n, .all_bytes_write_n,
    .out_enable_n, .sleep_request, .dq_in(dq_bus), .dq_out, .dq_oe);
  sbfs_port #(.ORG_X18(1'b1)) DUT_X18 (.clk, .rst_n, .addr, .pipelined_select_n,
    .depth_select_hi, .depth_select_lo_n, .processor_addr_strobe_n,
    .controller_addr_strobe_n, .burst_advance_n, .burst_order_interleave,
    .byte_write_lane_n, .byte_write_qualifier_n, .all_bytes_write_n,
    .out_enable_n, .sleep_request, .dq_in(dq_bus18), .dq_out(dq_out18), .dq_oe(dq_oe18));
  sbfs_master m (.clk, .addr, .pipelined_select_n, .depth_select_hi,
    .depth_select_lo_n, .processor_addr_strobe_n, .controller_addr_strobe_n,
    .burst_advance_n, .burst_order_interleave, .byte_write_lane_n,
    .byte_write_qualifier_n, .all_bytes_write_n, .dq_w, .dq_r(dq_bus), .dq_r2(dq_bus18),
    .dq_oe);
  function automatic logic [35:0] pat(int k);
    return 36'h2468ACE00 + 36'(k);
  endfunction
  task automatic chk_w(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: enable %b, expected %b", $time, got, exp);
    end
  endtask
  // Output enable stays off around writes so the port never fights the write data
  task automatic t_burst();
    out_enable_n = 1'b1;
    m.wr(19'h00104, {pat(3), pat(2), pat(1), pat(0)}, 6'h3E);
    repeat (4) m.step();
    out_enable_n = 1'b0;
    m.rd(19'h00105, 1'b0, d, oe, d2);
    chk_w({32'h0, oe}, 36'h00000000F);
    for (int k = 0; k < 4; k++) chk_w(d[k], pat((1 + k) % 4));
    for (int k = 0; k < 4; k++) chk_w(d2[k], pat((1 + k) % 4) & 36'h3FFFF);
    m.rd(19'h00105, 1'b1, d, oe, d2);
    for (int k = 0; k < 4; k++) chk_w(d[k], pat(1 ^ k));
    for (int k = 0; k < 4; k++) chk_w(d2[k], pat(1 ^ k) & 36'h3FFFF);
    $display("t_burst done");
  endtask
  task automatic t_lanes();
    out_enable_n = 1'b1;
    // Lane enables without the qualifier must not write
    m.wr(19'h00104, {4{36'h000000000}}, 6'h03);
    m.wr(19'h00104, {4{36'hFFFFFFFFF}}, 6'h29);
    repeat (4) m.step();
    out_enable_n = 1'b0;
    m.rd(19'h00104, 1'b0, d, oe, d2);
    for (int k = 0; k < 4; k++) chk_w(d[k], pat(k) | 36'h007FC01FF);
    for (int k = 0; k < 4; k++) chk_w(d2[k], (pat(k) | 36'h1FF) & 36'h3FFFF);
    $display("t_lanes done");
  endtask
  task automatic t_async();
    m.addr = 19'h00104;
    m.processor_addr_strobe_n = 1'b0;
    m.step();
    m.processor_addr_strobe_n = 1'b1;
    chk_b(dq_oe, 1'b1);
    chk_b(dq_oe18, 1'b1);
    #1 out_enable_n = 1'b1;
    #0.5 chk_b(dq_oe, 1'b0);
    out_enable_n = 1'b0;
    sleep_request = 1'b1;
    #0.5 chk_b(dq_oe, 1'b0);
    sleep_request = 1'b0;
    m.step();
    $display("t_async done");
  endtask
  task automatic t_desel();
    m.pipelined_select_n = 1'b1;
    m.rd(19'h00104, 1'b0, d, oe, d2);
    chk_w({32'h0, oe}, 36'h000000000);
    m.pipelined_select_n = 1'b0;
    $display("t_desel done");
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    t_burst();
    t_lanes();
    t_async();
    t_desel();
    conclude();
  end
endmodule // tb_top

// ---- src/sbfs_fifo.sv ----
// Write FIFO between the write pins and the storage array.
// Assumes both sides on clk; the drain side may stall.
`timescale 1ns/1ps
module sbfs_fifo #(
  parameter int W = 58,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } sbfs_fifo_s;

  sbfs_fifo_s st_r, st_nxt;
  logic [W-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = st_r.cnt != (PW+1)'(DEPTH);
  assign out_valid = st_r.cnt != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[st_r.rp];

  always_comb begin
    st_nxt = st_r;
    if (push) st_nxt.wp = st_r.wp + PW'(1);
    if (pop) st_nxt.rp = st_r.rp + PW'(1);
    st_nxt.cnt = st_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st_r <= '0;
    else st_r <= st_nxt;
  end

  always_ff @(posedge clk) begin
    if (push) mem[st_r.wp] <= in_data;
  end
endmodule // sbfs_fifo

// ---- src/sbfs_pkg.sv ----
// Shared constants and carriers for the burst SRAM port.
// Assumes one 250 MHz clock and a bus master synchronous to it.
package sbfs_pkg;
  localparam int ADDR_W = 19;
  localparam int WORD_AW = 18;
  localparam int DATA_W = 36;
  localparam int HALF_W = 18;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 4;
  localparam int FIRST_BEAT_CYC = 2;
  localparam int NEXT_BEAT_CYC = 1;
  localparam logic [1:0] BEAT_FIRST = 2'h0;
  localparam logic [1:0] BEAT_STEP = 2'h1;
  localparam logic [1:0] BEAT_LAST = 2'h3;
  localparam logic [3:0] MASK_ALL = 4'hF;
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [1:0] HALF_NONE = 2'h0;

  typedef struct packed {
    logic [WORD_AW-1:0] word;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] lanes;
  } sbfs_wr_s;

  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [1:0] beat;
    logic sel;
    logic rd;
    logic interleave;
    logic slp_s1;
    logic slp_s2;
    logic slp_s3;
    logic sleep;
  } sbfs_st_s;
endpackage

// ---- src/sbfs_port.sv ----
// Flow-through burst SRAM port with storage array and write FIFO.
// Assumes the bus master drives every synchronous pin from clk.
// Operation
// - The array serves as 256K x 36 or 512K x 18 on one data bus.
// - A two-bit counter loads the burst start and makes the later addresses.
// - All synchronous inputs are registered on the rising clock edge.
// - Output enable and sleep release the bus at once; sleep reaches the write path through a synchronizer.
// - Burst order high picks interleaved, low picks linear sequence.
// - Either the processor or the controller strobe starts a burst.
// - Address and selects are latched only on an edge with a strobe low.
// - Later burst addresses come from the counter, stepped by advance.
// - A four-beat burst runs 2-1-1-1 clock cycles.
`timescale 1ns/1ps
module sbfs_port #(
  parameter bit ORG_X18 = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Address and selects
  input wire logic [sbfs_pkg::ADDR_W-1:0] addr,
  input wire logic pipelined_select_n,
  input wire logic depth_select_hi,
  input wire logic depth_select_lo_n,
  // Burst control
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic burst_order_interleave,
  // Write enables
  input wire logic [sbfs_pkg::LANES-1:0] byte_write_lane_n,
  input wire logic byte_write_qualifier_n,
  input wire logic all_bytes_write_n,
  // Asynchronous controls
  input wire logic out_enable_n,
  input wire logic sleep_request,
  // Data bus, split for the pad
  input wire logic [sbfs_pkg::DATA_W-1:0] dq_in,
  output logic [sbfs_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe
);
  localparam int WAW = sbfs_pkg::WORD_AW;
  localparam int DW = sbfs_pkg::DATA_W;
  localparam int HW = sbfs_pkg::HALF_W;
  localparam int LW = sbfs_pkg::LANE_W;
  localparam int WR_W = $bits(sbfs_pkg::sbfs_wr_s);

  sbfs_pkg::sbfs_st_s st_r, st_nxt;
  sbfs_pkg::sbfs_wr_s wr_in, wr_out;
  logic [WAW-1:0] rd_index;

  logic strobe, chip_sel, sel_now, proc_start;
  logic [3:0] lane_mask;
  logic wr_want, stall, step;
  logic [1:0] beat_now;
  logic [sbfs_pkg::ADDR_W-1:0] base_now, cur_addr, wr_addr;
  logic fifo_in_ready, fifo_out_valid, drain_ready;
  logic [WR_W-1:0] fifo_out_bits;
  logic [DW-1:0] rd_word;

  // Low address bits for a given beat
  function automatic logic [1:0] burst_low(
    input logic [1:0] start,
    input logic [1:0] beat,
    input logic il
  );
    burst_low = il ? (start ^ beat) : 2'(start + beat);
  endfunction

  assign strobe = !processor_addr_strobe_n || !controller_addr_strobe_n;
  assign proc_start = !processor_addr_strobe_n;
  assign chip_sel = !pipelined_select_n && depth_select_hi && !depth_select_lo_n;
  assign sel_now = strobe ? chip_sel : st_r.sel;

  // Byte lanes for the write at this edge
  always_comb begin
    lane_mask = sbfs_pkg::MASK_NONE;
    if (!all_bytes_write_n) begin
      lane_mask = sbfs_pkg::MASK_ALL;
    end else if (!byte_write_qualifier_n) begin
      lane_mask = ~byte_write_lane_n;
    end
    if (ORG_X18) lane_mask[3:2] = sbfs_pkg::HALF_NONE;
  end

  // A processor-strobe edge never queues a write; sleep blocks writes
  assign wr_want = sel_now && (lane_mask != sbfs_pkg::MASK_NONE)
    && !(strobe && proc_start) && !st_r.sleep;
  // A full FIFO holds the counter so no beat is skipped
  assign stall = wr_want && !fifo_in_ready;
  assign step = !strobe && !burst_advance_n && !stall;

  assign base_now = strobe ? addr : st_r.base;
  assign beat_now = strobe ? sbfs_pkg::BEAT_FIRST :
    (step ? 2'(st_r.beat + sbfs_pkg::BEAT_STEP) : st_r.beat);
  assign wr_addr = {base_now[sbfs_pkg::ADDR_W-1:2],
    burst_low(base_now[1:0], beat_now, burst_order_interleave)};
  assign cur_addr = {st_r.base[sbfs_pkg::ADDR_W-1:2],
    burst_low(st_r.base[1:0], st_r.beat, st_r.interleave)};

  always_comb begin
    st_nxt = st_r;
    st_nxt.slp_s1 = sleep_request;
    st_nxt.slp_s2 = st_r.slp_s1;
    st_nxt.slp_s3 = st_r.slp_s2;
    if (st_r.slp_s2 == st_r.slp_s3) st_nxt.sleep = st_r.slp_s3;
    st_nxt.interleave = burst_order_interleave;
    if (strobe) begin
      st_nxt.base = addr;
      st_nxt.sel = chip_sel;
    end
    st_nxt.beat = beat_now;
    st_nxt.rd = sel_now && !wr_want;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st_r <= '0;
    else st_r <= st_nxt;
  end

  // Write entry, mapped onto the 36-bit array for either organisation
  always_comb begin
    if (ORG_X18) begin
      wr_in.word = wr_addr[sbfs_pkg::ADDR_W-1:1];
      wr_in.data = {dq_in[HW-1:0], dq_in[HW-1:0]};
      wr_in.lanes = wr_addr[0] ? {lane_mask[1:0], sbfs_pkg::HALF_NONE}
        : {sbfs_pkg::HALF_NONE, lane_mask[1:0]};
    end else begin
      wr_in.word = wr_addr[WAW-1:0];
      wr_in.data = dq_in;
      wr_in.lanes = lane_mask;
    end
  end

  // The FIFO entry is the input register for write data
  sbfs_fifo #(
    .W(WR_W),
    .DEPTH(sbfs_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(wr_want),
    .in_ready(fifo_in_ready),
    .in_data(wr_in),
    .out_valid(fifo_out_valid),
    .out_ready(drain_ready),
    .out_data(fifo_out_bits)
  );

  assign wr_out = fifo_out_bits;
  // The array is not written while asleep; queued writes wait in the FIFO
  assign drain_ready = !st_r.sleep;

  // One array per lane keeps a single writer on each; the read index is shared
  assign rd_index = ORG_X18 ? cur_addr[sbfs_pkg::ADDR_W-1:1] : cur_addr[WAW-1:0];

  for (genvar g = 0; g < sbfs_pkg::LANES; g++) begin : g_lane
    logic [LW-1:0] lane_mem [2**WAW];
    always_ff @(posedge clk) begin
      if (fifo_out_valid && drain_ready && wr_out.lanes[g]) begin
        lane_mem[wr_out.word] <= wr_out.data[g*LW +: LW];
      end
    end
    assign rd_word[g*LW +: LW] = lane_mem[rd_index];
  end

  // Flow-through read: data follows the registered address in the same cycle.
  // A read of a word still queued in the FIFO returns the old contents.
  always_comb begin
    dq_out = rd_word;
    if (ORG_X18) begin
      dq_out = '0;
      dq_out[HW-1:0] = cur_addr[0] ? rd_word[DW-1:HW] : rd_word[HW-1:0];
    end
  end

  // Raw pins, no clock, so the bus is released at once
  assign dq_oe = st_r.rd && !out_enable_n && !sleep_request;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_load;
    strobe |=> st_r.base == $past(addr) && st_r.beat == sbfs_pkg::BEAT_FIRST;
  endproperty
  a_load: assert property (p_load) else $error("Strobe did not load address");

  property p_hold;
    !strobe |=> $stable(st_r.base) && $stable(st_r.sel);
  endproperty
  a_hold: assert property (p_hold) else $error("Address moved without strobe");

  property p_step;
    step |=> st_r.beat == 2'($past(st_r.beat) + 2'h1);
  endproperty
  a_step: assert property (p_step) else $error("Counter did not step");

  property p_still;
    !strobe && burst_advance_n |=> $stable(st_r.beat);
  endproperty
  a_still: assert property (p_still) else $error("Counter stepped unasked");

  property p_linear;
    !st_r.interleave |-> cur_addr[1:0] == 2'(st_r.base[1:0] + st_r.beat);
  endproperty
  a_linear: assert property (p_linear) else $error("Linear order wrong");

  property p_interleave;
    st_r.interleave |-> cur_addr[1:0] == (st_r.base[1:0] ^ st_r.beat);
  endproperty
  a_interleave: assert property (p_interleave) else $error("Interleaved order wrong");

  property p_oe_off;
    out_enable_n || sleep_request |-> !dq_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("Bus driven while disabled");

  property p_global;
    !all_bytes_write_n && !ORG_X18 |-> lane_mask == 4'hF;
  endproperty
  a_global: assert property (p_global) else $error("Global write lost lanes");

  property p_lanes;
    all_bytes_write_n && !ORG_X18 |->
      lane_mask == (byte_write_qualifier_n ? 4'h0 : ~byte_write_lane_n);
  endproperty
  a_lanes: assert property (p_lanes) else $error("Lane enables wrong");

  property p_first;
    strobe && proc_start && chip_sel && !out_enable_n && !sleep_request
      ##1 !out_enable_n && !sleep_request |-> dq_oe;
  endproperty
  a_first: assert property (p_first) else $error("First beat not driven");

  property p_burst;
    strobe ##1 (!strobe && !burst_advance_n && !stall) [*3] |=> st_r.beat == 2'h3;
  endproperty
  a_burst: assert property (p_burst) else $error("Burst not 2-1-1-1");

  // Capture, select, write-path and output checks
  property p_desel;
    strobe && !chip_sel |=> !dq_oe;
  endproperty
  a_desel: assert property (p_desel) else $error("Deselected burst drove the bus");

  property p_sel_load;
    strobe |=> st_r.sel == $past(chip_sel);
  endproperty
  a_sel_load: assert property (p_sel_load) else $error("Selects not latched");

  property p_mode_reg;
    1'b1 |=> st_r.interleave == $past(burst_order_interleave);
  endproperty
  a_mode_reg: assert property (p_mode_reg) else $error("Burst order not registered");

  property p_x18_upper;
    ORG_X18 |-> dq_out[DW-1:HW] == '0;
  endproperty
  a_x18_upper: assert property (p_x18_upper) else $error("Upper half driven in x18");

  property p_x18_lanes;
    ORG_X18 |-> lane_mask[3:2] == sbfs_pkg::HALF_NONE;
  endproperty
  a_x18_lanes: assert property (p_x18_lanes) else $error("Upper lanes enabled in x18");

  property p_push;
    wr_want && fifo_in_ready |=> fifo_out_valid;
  endproperty
  a_push: assert property (p_push) else $error("Write not queued");

  property p_wr_start;
    wr_want && strobe |-> wr_addr == addr;
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("First write address wrong");

  property p_ctrl_write;
    !controller_addr_strobe_n && processor_addr_strobe_n && chip_sel && !all_bytes_write_n
      && !st_r.sleep && fifo_in_ready |-> wr_want;
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("Controller write lost");

  property p_wr_quiet;
    wr_want |=> !dq_oe;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("Bus driven after write");

  property p_oe_on;
    st_r.rd && !out_enable_n && !sleep_request |-> dq_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("Read data not driven");

  c_linear: cover property (strobe && !burst_order_interleave ##1 step [*3]);
  c_interleave: cover property (strobe && burst_order_interleave ##1 step [*3]);
  c_write: cover property (wr_want && fifo_in_ready);
  c_full: cover property (stall);
  c_desel: cover property (strobe && !chip_sel);
endmodule // sbfs_port
